// [hdl/msra_consts.vh]
// constants for the master-synchronised rotary axis block
`ifndef MSRA_CONSTS_VH
`define MSRA_CONSTS_VH
// ----------------------------------------------------------------
// apb register byte offsets
// ----------------------------------------------------------------
`define MSRA_A_CTRL      12'h000
`define MSRA_A_STATUS    12'h004
`define MSRA_A_TARGET    12'h008
`define MSRA_A_SPEED     12'h00c
`define MSRA_A_ACCEL     12'h010
`define MSRA_A_LEAD      12'h014
`define MSRA_A_DELAY     12'h018
`define MSRA_A_ACT_LO    12'h01c
`define MSRA_A_ACT_HI    12'h020
`define MSRA_A_MST_LO    12'h024
`define MSRA_A_MST_HI    12'h028
`define MSRA_A_SETPOINT  12'h02c
`define MSRA_A_ACTPOS    12'h030
`define MSRA_A_CAP_ACT   12'h034
`define MSRA_A_CAP_MST   12'h038
`define MSRA_A_START     12'h03c
// ----------------------------------------------------------------
// ctrl field positions
// ----------------------------------------------------------------
`define MSRA_C_ACT_MODE_LO 0
`define MSRA_C_ACT_MODE_HI 2
`define MSRA_C_MST_EN      3
`define MSRA_C_TRACK_EN    4
`define MSRA_C_SMP_EN      5
`define MSRA_C_LEAD_EN     6
// start register fields
`define MSRA_S_FOLLOW      0
`define MSRA_S_DIR         1
// ----------------------------------------------------------------
// rotary policy codes
// ----------------------------------------------------------------
`define MSRA_ROT_OFF   3'h0
`define MSRA_ROT_WRAP  3'h1
`define MSRA_ROT_SHORT 3'h2
`define MSRA_ROT_SET   3'h3
`define MSRA_ROT_POS   3'h4
`define MSRA_ROT_NEG   3'h5
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MSRA_CYCLE_US  400
`define MSRA_CLK_MHZ   100
`define MSRA_CYCLE_CLKS (`MSRA_CYCLE_US * `MSRA_CLK_MHZ)
`endif

// [hdl/msra_axis.v]
// position setpoint logic with master following and rotary wrapping
`include "msra_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module msra_axis #(
   parameter CYCLE_CLKS = `MSRA_CYCLE_CLKS,
   parameter PW         = 32
) (
   input  wire          clk_sys,
   input  wire          rst_b,
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [11:0]   paddr,
   input  wire [31:0]   pwdata,
   output reg  [31:0]   prdata,
   output wire          pready,
   output wire          pslverr,
   input  wire [PW-1:0] master_pos,
   input  wire [PW-1:0] actual_pos,
   input  wire          sample_in,
   output reg  [PW-1:0] pos_setpoint,
   output wire          set_active
);
   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   reg  [6:0]    ctrl_q;
   reg  [PW-1:0] target_q;
   reg  [PW-1:0] speed_q;
   reg  [PW-1:0] accel_q;
   reg  [PW-1:0] lead_q;
   reg  [PW-1:0] delay_q;
   reg  [PW-1:0] alo_q;
   reg  [PW-1:0] ahi_q;
   reg  [PW-1:0] mlo_q;
   reg  [PW-1:0] mhi_q;
   reg  [1:0]    set_opt_q;
   reg           start_req_q;
   wire          acc = psel & penable;
   wire          wr  = acc & pwrite;
   wire          start_wr = wr & (paddr == `MSRA_A_START);
   reg           bad;

   assign pready  = 1'b1;
   assign pslverr = acc & bad;

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q   <= 7'h00;
         target_q <= {PW{1'b0}};
         speed_q  <= {PW{1'b0}};
         accel_q  <= {PW{1'b0}};
         lead_q   <= {PW{1'b0}};
         delay_q  <= {PW{1'b0}};
         alo_q    <= {PW{1'b0}};
         ahi_q    <= {PW{1'b0}};
         mlo_q    <= {PW{1'b0}};
         mhi_q    <= {PW{1'b0}};
         set_opt_q <= 2'h0;
      end else if (wr) begin
         case (paddr)
            `MSRA_A_CTRL: begin
               ctrl_q <= pwdata[6:0];
            end
            `MSRA_A_TARGET: begin
               target_q <= pwdata[PW-1:0];
            end
            `MSRA_A_SPEED: begin
               speed_q <= pwdata[PW-1:0];
            end
            `MSRA_A_ACCEL: begin
               accel_q <= pwdata[PW-1:0];
            end
            `MSRA_A_LEAD: begin
               lead_q <= pwdata[PW-1:0];
            end
            `MSRA_A_DELAY: begin
               delay_q <= pwdata[PW-1:0];
            end
            `MSRA_A_ACT_LO: begin
               alo_q <= pwdata[PW-1:0];
            end
            `MSRA_A_ACT_HI: begin
               ahi_q <= pwdata[PW-1:0];
            end
            `MSRA_A_MST_LO: begin
               mlo_q <= pwdata[PW-1:0];
            end
            `MSRA_A_MST_HI: begin
               mhi_q <= pwdata[PW-1:0];
            end
            `MSRA_A_START: begin
               set_opt_q <= pwdata[1:0];
            end
            default: ;
         endcase
      end
   end

   wire [2:0] act_mode = ctrl_q[`MSRA_C_ACT_MODE_HI:`MSRA_C_ACT_MODE_LO];
   wire       mst_rot  = ctrl_q[`MSRA_C_MST_EN];
   wire       track_en = ctrl_q[`MSRA_C_TRACK_EN];
   wire       smp_en   = ctrl_q[`MSRA_C_SMP_EN];
   wire       lead_en  = ctrl_q[`MSRA_C_LEAD_EN];
   wire       follow_opt = set_opt_q[`MSRA_S_FOLLOW];
   wire       dir_opt    = set_opt_q[`MSRA_S_DIR];

   // ----------------------------------------------------------------
   // control cycle tick
   // ----------------------------------------------------------------
   localparam [31:0] CYC_LAST = CYCLE_CLKS - 1;
   reg [31:0] cyc_q;
   wire       tick = (cyc_q == CYC_LAST);
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cyc_q <= 32'h0;
      end else if (tick) begin
         cyc_q <= 32'h0;
      end else begin
         cyc_q <= cyc_q + 32'h1;
      end
   end

   // ----------------------------------------------------------------
   // wrapping helpers
   // ----------------------------------------------------------------
   function [PW-1:0] wrap;
      input [PW-1:0] p, lo, hi;
      input          en;
      begin
         if (!en)
            wrap = p;
         else if ($signed(p) >= $signed(hi))
            wrap = p - (hi - lo);
         else if ($signed(p) < $signed(lo))
            wrap = p + (hi - lo);
         else
            wrap = p;
      end
   endfunction

   wire act_rot = (act_mode != `MSRA_ROT_OFF);
   wire [PW-1:0] mst_w = wrap(master_pos, mlo_q, mhi_q, mst_rot);
   wire [PW-1:0] act_w = wrap(actual_pos, alo_q, ahi_q, act_rot);

   // ----------------------------------------------------------------
   // sample capture and start sequencing
   // ----------------------------------------------------------------
   reg           smp_d_q;
   reg           smp_vld_q;
   reg           smp_vld_d;
   reg           pend_q;
   reg           pend_d;
   reg           dly_run_q;
   reg           dly_run_d;
   reg  [PW-1:0] cap_act_q;
   reg  [PW-1:0] cap_mst_q;
   reg  [PW-1:0] dly_q;
   reg  [PW-1:0] dly_d;
   wire          smp_edge = sample_in & ~smp_d_q & smp_en;
   // a start is only consumed while tracking mode can take it
   wire          take     = tick & pend_q & track_en;
   wire          dly_zero = (dly_q == {PW{1'b0}});
   wire          dly_done = dly_run_q & ~smp_edge & dly_zero;

   // the pair stays valid until a start consumes it; a new edge wins
   always @* begin
      smp_vld_d = smp_vld_q;
      if (take) begin
         smp_vld_d = 1'b0;
      end
      if (smp_edge) begin
         smp_vld_d = 1'b1;
      end
   end

   // a fresh sample edge restarts the delay from the configured value
   always @* begin
      dly_run_d = dly_run_q;
      dly_d     = dly_q;
      if (dly_done) begin
         dly_run_d = 1'b0;
      end else if (dly_run_q & ~smp_edge) begin
         dly_d = dly_q - {{PW-1{1'b0}}, 1'b1};
      end
      if (smp_edge & lead_en) begin
         dly_run_d = 1'b1;
         dly_d     = delay_q;
      end
   end

   // set wins over consume, so a start landing on the tick is kept
   always @* begin
      pend_d = pend_q;
      if (take) begin
         pend_d = 1'b0;
      end
      if (start_wr | dly_done) begin
         pend_d = 1'b1;
      end
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         smp_d_q   <= 1'b0;
         smp_vld_q <= 1'b0;
         cap_act_q <= {PW{1'b0}};
         cap_mst_q <= {PW{1'b0}};
         pend_q    <= 1'b0;
         dly_run_q <= 1'b0;
         dly_q     <= {PW{1'b0}};
      end else begin
         smp_d_q   <= sample_in;
         smp_vld_q <= smp_vld_d;
         pend_q    <= pend_d;
         dly_run_q <= dly_run_d;
         dly_q     <= dly_d;
         if (smp_edge) begin
            cap_act_q <= act_w;
            cap_mst_q <= mst_w;
         end
      end
   end

   // ----------------------------------------------------------------
   // setpoint generator, evaluated on each tick
   // ----------------------------------------------------------------
   reg           follow_q;
   reg           busy_q;
   reg           dir_neg_q;
   reg  [PW-1:0] base_q;
   reg  [PW-1:0] offs_q;
   reg  [PW-1:0] vel_q;
   reg  [PW-1:0] mprev_q;
   reg  [PW-1:0] mvel_q;
   wire [PW-1:0] span   = ahi_q - alo_q;
   wire [PW-1:0] fwd    = wrap(target_q - base_q + alo_q, alo_q, ahi_q,
                               1'b1) - alo_q;
   wire [PW-1:0] dist_d = act_rot ? fwd : target_q - base_q;
   // signed error toward target with direction policy applied
   reg  [PW-1:0] err;
   always @* begin
      err = target_q - base_q;
      case (act_mode)
         `MSRA_ROT_SHORT: begin
            err = (fwd < (span >> 1)) ? fwd : fwd - span;
         end
         `MSRA_ROT_SET: begin
            // a target already reached must not cost a whole turn
            err = (dir_neg_q & (fwd != {PW{1'b0}})) ? fwd - span : fwd;
         end
         `MSRA_ROT_POS: begin
            err = fwd;
         end
         `MSRA_ROT_NEG: begin
            err = (fwd == {PW{1'b0}}) ? fwd : fwd - span;
         end
         default: begin
            err = dist_d;
         end
      endcase
   end
   wire [PW-1:0] step_lim = mvel_q + speed_q;
   wire [PW-1:0] abs_err  = err[PW-1] ? -err : err;
   wire [PW-1:0] vmag     = (vel_q + accel_q > step_lim) ?
                            step_lim : vel_q + accel_q;
   wire [PW-1:0] step     = (abs_err < vmag) ? abs_err : vmag;
   wire [PW-1:0] lead_v   = lead_en ? lead_q : {PW{1'b0}};
   // offset of the master since the sample was taken, less that of the actual axis
   wire [PW-1:0] smp_corr = (smp_vld_q & smp_en) ?
                            (mst_w - cap_mst_q) - (act_w - cap_act_q) :
                            {PW{1'b0}};
   // follow origin: master at the start, less sample offset and lead
   wire [PW-1:0] sync_ref  = mst_w - smp_corr - lead_v;
   wire [PW-1:0] base_mv   = err[PW-1] ? base_q - step : base_q + step;
   wire [PW-1:0] next_base = wrap(base_mv, alo_q, ahi_q, act_rot);
   wire [PW-1:0] follow_sp = wrap(base_q + mst_w, alo_q, ahi_q, act_rot);

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         follow_q  <= 1'b0;
         busy_q    <= 1'b0;
         dir_neg_q <= 1'b0;
         base_q    <= {PW{1'b0}};
         offs_q    <= {PW{1'b0}};
         vel_q     <= {PW{1'b0}};
         mprev_q   <= {PW{1'b0}};
         mvel_q    <= {PW{1'b0}};
         pos_setpoint <= {PW{1'b0}};
      end else if (tick) begin
         mprev_q <= mst_w;
         mvel_q  <= mst_w - mprev_q;
         if (take) begin
            busy_q    <= 1'b1;
            dir_neg_q <= dir_opt;
            follow_q  <= follow_opt;
            if (follow_opt) begin
               offs_q <= sync_ref;
               base_q <= act_w - sync_ref;
               vel_q  <= {PW{1'b0}};
            end else begin
               base_q <= pos_setpoint;
               if (follow_q) begin
                  vel_q <= mvel_q;
               end
            end
         end else if (busy_q) begin
            if (err == {PW{1'b0}}) begin
               busy_q <= 1'b0;
            end else begin
               base_q <= next_base;
               vel_q  <= step;
            end
         end
         if (follow_q) begin
            pos_setpoint <= follow_sp;
         end else begin
            pos_setpoint <= base_q;
         end
      end
   end

   assign set_active = busy_q | pend_q | dly_run_q;

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   always @* begin
      bad    = 1'b0;
      prdata = 32'h0;
      case (paddr)
         `MSRA_A_CTRL:     prdata = {25'h0, ctrl_q};
         `MSRA_A_STATUS:   prdata = {28'h0, smp_vld_q, follow_q,
                                     pend_q, set_active};
         `MSRA_A_TARGET:   prdata = target_q;
         `MSRA_A_SPEED:    prdata = speed_q;
         `MSRA_A_ACCEL:    prdata = accel_q;
         `MSRA_A_LEAD:     prdata = lead_q;
         `MSRA_A_DELAY:    prdata = delay_q;
         `MSRA_A_ACT_LO:   prdata = alo_q;
         `MSRA_A_ACT_HI:   prdata = ahi_q;
         `MSRA_A_MST_LO:   prdata = mlo_q;
         `MSRA_A_MST_HI:   prdata = mhi_q;
         `MSRA_A_SETPOINT: prdata = pos_setpoint;
         `MSRA_A_ACTPOS:   prdata = act_w;
         `MSRA_A_CAP_ACT:  prdata = cap_act_q;
         `MSRA_A_CAP_MST:  prdata = cap_mst_q;
         `MSRA_A_START:    prdata = {30'h0, set_opt_q};
         default:          bad    = 1'b1;
      endcase
   end
endmodule // msra_axis
`default_nettype wire

// [sim/msra_chk_assertions.sv]
// assertion checker for the master-synced rotary axis block
`include "msra_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module msra_chk #(
   parameter CYCLE_CLKS = 20,
   parameter PW         = 32
) (
   input wire          clk_sys,
   input wire          rst_b,
   input wire          psel,
   input wire          penable,
   input wire          pwrite,
   input wire [11:0]   paddr,
   input wire [31:0]   pwdata,
   input wire [31:0]   prdata,
   input wire          pready,
   input wire          pslverr,
   input wire [PW-1:0] pos_setpoint,
   input wire          set_active
);
   logic [2:0]    mode_q;
   logic [PW-1:0] lo_q, hi_q, last_q;
   int            quiet_q;
   wire           acc = psel && penable;
   wire           wr = acc && pwrite;
   wire           moved = pos_setpoint != last_q;
   wire           unm = paddr > `MSRA_A_START;
   // quiet_q saturates so a long idle never wraps it
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mode_q <= 3'h0;
         lo_q <= '0;
         hi_q <= '0;
         last_q <= '0;
         quiet_q <= 0;
      end else begin
         if (wr && paddr == `MSRA_A_CTRL) mode_q <= pwdata[2:0];
         if (wr && paddr == `MSRA_A_ACT_LO) lo_q <= pwdata;
         if (wr && paddr == `MSRA_A_ACT_HI) hi_q <= pwdata;
         last_q <= pos_setpoint;
         if (moved) quiet_q <= 0;
         else if (quiet_q < CYCLE_CLKS) quiet_q <= quiet_q + 1;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   property p_tick; moved |-> quiet_q >= CYCLE_CLKS - 2; endproperty
   a_tick: assert property (p_tick) else $error("step off tick");
   property p_hold; moved |=> !moved [*8]; endproperty
   a_hold: assert property (p_hold) else $error("step not held");
   property p_stat;
      acc && !pwrite && paddr == `MSRA_A_STATUS |-> prdata[0] == set_active;
   endproperty
   a_stat: assert property (p_stat) else $error("status bit wrong");
   property p_start; wr && paddr == `MSRA_A_START |=> set_active; endproperty
   a_start: assert property (p_start) else $error("start not seen");
   // a range is only judged in a rotary mode and while lo_q is below hi_q
   property p_range;
      moved && mode_q != 3'h0 && $signed(lo_q) < $signed(hi_q) |->
         !($signed(pos_setpoint) < $signed(lo_q)) &&
         $signed(pos_setpoint) < $signed(hi_q);
   endproperty
   a_range: assert property (p_range) else $error("out of range");
   property p_rdy; acc |-> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready");
   property p_err; acc && paddr[1:0] == 2'h0 |-> pslverr == unm; endproperty
   a_err: assert property (p_err) else $error("slverr wrong");
   property p_rd0; acc && !pwrite && unm |-> prdata == 32'h0; endproperty
   a_rd0: assert property (p_rd0) else $error("unmapped data");
endmodule // msra_chk
bind msra_axis msra_chk #(.CYCLE_CLKS(CYCLE_CLKS), .PW(PW)) u_chk (.*);
`default_nettype wire

// [sim/msra_partner.sv]
// far side: master encoder and the servo loop of the slave axis
`timescale 1ns/10ps
`default_nettype none
module msra_partner #(
   parameter PW = 32
) (
   input  wire           clk_sys,
   input  wire           rst_b,
   input  wire  [PW-1:0] pos_setpoint,
   input  wire           ld,
   input  wire  [PW-1:0] ld_val,
   input  wire  [PW-1:0] stp,
   output logic [PW-1:0] master_pos,
   output logic [PW-1:0] actual_pos
);
   // encoder counts stp per clock; servo loop lags one clock
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         master_pos <= '0;
         actual_pos <= '0;
      end else begin
         master_pos <= ld ? ld_val : master_pos + stp;
         actual_pos <= pos_setpoint;
      end
   end
endmodule // msra_partner
`default_nettype wire

// [sim/msra_axis_test.sv]
// self-checking bench for the master-synced rotary axis block
`include "msra_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module msra_axis_test;
   localparam int CYC = 20;
   logic        clk_sys = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, sample_in = 1'b0, ld = 1'b0, err;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, ld_val = 32'h0, stp = 32'h0;
   logic [31:0] seed = 32'h950b, rd, sp0, sp1;
   logic [3:0]  dirv = 4'b0010, fwdv = 4'b0101;
   wire  [31:0] prdata, master_pos, actual_pos, pos_setpoint;
   wire         pready, pslverr, set_active;
   int          n_fail = 0, check_count = 0, cyc = 0, i, n;
   msra_axis #(.CYCLE_CLKS(CYC), .PW(32)) dut (.*);
   msra_partner #(.PW(32)) u_far (.*);
   initial forever #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (++cyc == 40000) begin
      n_fail++;
      complete_run();
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   // true when the first step went up, modulo the 1000-count range
   function automatic logic fwd(input logic [31:0] a, b);
      int d;
      d = ((int'(b) - int'(a)) % 1000 + 1000) % 1000;
      return d != 0 && d < 500;
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1 && ++k < 50);
      if (k >= 50) n_fail++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdk(input string nm, input logic [11:0] a,
                      input logic [31:0] m, exp);
      apb(1'b0, a, 32'h0);
      chk(nm, rd & m, exp);
   endtask
   task automatic wait_tk(input int t);
      repeat (t * CYC) @(posedge clk_sys);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk_sys);
      rst_b <= 1'b1;
      for (i = 0; i < 16; i++) rdk("rst", 12'(i * 4), '1, 32'h0);
      rdk("unmapped", 12'h040, '1, 32'h0);
      chk("slverr", {31'h0, err}, 32'h1);
      for (i = 2; i < 11; i++) begin
         seed = xs(seed);
         apb(1'b1, 12'(i * 4), seed);
         rdk("rw", 12'(i * 4), '1, seed);
      end
      seed = xs(seed);
      ld_val <= seed;
      ld <= 1'b1;
      apb(1'b1, `MSRA_A_CTRL, 32'h20);
      ld <= 1'b0;
      sample_in <= 1'b1;
      repeat (3) @(posedge clk_sys);
      sample_in <= 1'b0;
      rdk("cap act", `MSRA_A_CAP_ACT, '1, 32'h0);
      rdk("cap mst", `MSRA_A_CAP_MST, '1, ld_val);
      rdk("smp ok", `MSRA_A_STATUS, 32'h8, 32'h8);
      apb(1'b1, `MSRA_A_START, 32'h1);
      wait_tk(2);
      chk("active", {31'h0, set_active}, 32'h1);
      chk("no move", pos_setpoint, 32'h0);
      rdk("pending", `MSRA_A_STATUS, 32'h6, 32'h2);
      apb(1'b1, `MSRA_A_SPEED, 32'h0);
      apb(1'b1, `MSRA_A_ACCEL, 32'h0);
      stp <= 32'h3;
      apb(1'b1, `MSRA_A_CTRL, 32'h30);
      wait_tk(2);
      rdk("follow", `MSRA_A_STATUS, 32'he, 32'h4);
      sp0 = pos_setpoint;
      wait_tk(1);
      chk("tracks", {31'h0, pos_setpoint !== sp0}, 32'h1);
      stp <= 32'h0;
      apb(1'b1, `MSRA_A_ACT_HI, 32'h3e8);
      apb(1'b1, `MSRA_A_ACT_LO, 32'h0);
      apb(1'b1, `MSRA_A_SPEED, 32'h32);
      apb(1'b1, `MSRA_A_ACCEL, 32'h3);
      apb(1'b1, `MSRA_A_TARGET, 32'h0);
      for (i = 0; i < 4; i++) begin
         apb(1'b1, `MSRA_A_CTRL, 32'h10 | 32'(`MSRA_ROT_WRAP + i + 1));
         apb(1'b1, `MSRA_A_START, {30'h0, dirv[i], 1'b0});
         wait_tk(2);
         if (i == 0) rdk("unfollow", `MSRA_A_STATUS, 32'h4, 32'h0);
         n = 0;
         while (set_active !== 1'b0 && n++ < 8000) @(posedge clk_sys);
         if (n >= 8000) n_fail++;
         sp0 = pos_setpoint;
         apb(1'b1, `MSRA_A_TARGET, (sp0 + (i == 2 ? 988 : 12)) % 1000);
         apb(1'b1, `MSRA_A_START, {30'h0, dirv[i], 1'b0});
         n = 0;
         while (pos_setpoint === sp0 && n++ < 5 * CYC) @(posedge clk_sys);
         if (n >= 5 * CYC) n_fail++;
         sp1 = pos_setpoint;
         chk("dir", 32'(fwd(sp0, sp1)), 32'(fwdv[i]));
      end
      complete_run();
   end
endmodule // msra_axis_test
`default_nettype wire
